// [rtl/pps_dwell_timer.sv]
// Dwell timer that counts whole time units of a fixed number of cycles.
`timescale 1ns/1ps
`default_nettype none
module pps_dwell_timer #(
	parameter int UNIT_CYCLES = 500000
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        load,
	input  wire logic [15:0] units,
	output var  logic        done
);
	localparam int PRE_W = $clog2(UNIT_CYCLES + 1);

	logic [PRE_W-1:0] pre_r;
	logic [PRE_W-1:0] pre_nxt;
	logic [15:0]      left_r;
	logic [15:0]      left_nxt;
	logic             fresh_r;

	initial begin
		if (UNIT_CYCLES < 1) $error("UNIT_CYCLES must be at least one");
	end

	// Done waits one cycle after a load so that it never answers for the old count.
	assign done = (left_r == 16'h0000) && !fresh_r;

	always_comb begin
		pre_nxt  = pre_r;
		left_nxt = left_r;
		if (load) begin
			pre_nxt  = '0;
			left_nxt = units;
		end else if (left_r != 16'h0000) begin
			if (pre_r == PRE_W'(UNIT_CYCLES - 1)) begin
				pre_nxt  = '0;
				left_nxt = left_r - 16'h0001;
			end else begin
				pre_nxt = pre_r + PRE_W'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_r   <= '0;
			left_r  <= 16'h0000;
			fresh_r <= 1'b0;
		end else begin
			pre_r   <= pre_nxt;
			left_r  <= left_nxt;
			fresh_r <= load;
		end
	end
endmodule
`default_nettype wire

// [rtl/pps_pkg.sv]
// Constants, register map and state type of the point-to-point step sequencer.
package pps_pkg;
	localparam int          CLK_HZ            = 10_000_000;
	localparam int          DWELL_UNIT_MS     = 50;
	localparam int          DWELL_UNIT_CYC    = DWELL_UNIT_MS * (CLK_HZ / 1000);
	localparam logic [15:0] START_DELAY_UNITS = 16'h0001;
	localparam int          NUM_STEPS         = 16;
	localparam int          ADDR_W            = 12;

	localparam logic [11:0] OFS_RSVD   = 12'h000;
	localparam logic [11:0] OFS_MODE   = 12'h004;
	localparam logic [11:0] OFS_TARGET = 12'h008;
	localparam logic [11:0] OFS_FIRST  = 12'h00C;
	localparam logic [11:0] OFS_LAST   = 12'h010;
	localparam logic [11:0] OFS_CTRL   = 12'h014;
	localparam logic [11:0] OFS_STATUS = 12'h018;
	localparam logic [11:0] OFS_DWELL  = 12'h040;

	localparam int RUN_LSB  = 0;
	localparam int STEP_LSB = 4;
	localparam int SIN_LSB  = 8;
	localparam int CTRL_RESTART = 0;

	localparam logic [15:0] MODE_RST   = 16'h0000;
	localparam logic [15:0] TARGET_RST = 16'h0000;
	localparam logic [15:0] FIRST_RST  = 16'h0000;
	localparam logic [15:0] LAST_RST   = 16'h000F;
	localparam logic [15:0] DWELL_RST  = 16'h0001;

	typedef enum logic [1:0] {
		PPS_IDLE  = 2'b00,
		PPS_DELAY = 2'b01,
		PPS_RUN   = 2'b11,
		PPS_HOLD  = 2'b10
	} pps_state_t;

	function automatic logic pps_is_dwell(input logic [11:0] addr);
		pps_is_dwell = (addr >= OFS_DWELL) && (addr < OFS_DWELL + 12'h040) && (addr[1:0] == 2'b00);
	endfunction
endpackage

// [rtl/pps_sequencer.sv]
// Point-to-point step sequencer with APB register access.
// Summary of operation
// [R1] Run mode 0/2 cyclic, 1/3 single run.
// [R2] Modes 2/3 swap start and homing inputs.
// [R3] Step mode 0: timed steps, servo-on starts.
// [R4] Step mode 1: advance input steps, never halts.
// [R5] Step mode 2: timed steps, start input gates.
// [R6] Step mode 3: advance input steps, start gates.
// [R7] Start-gated modes: restart returns to first step (ignored in PPS_HOLD, which keeps the last step).
// [R8] Step input mode selects level or edge.
// [R9] Program mode selects incremental or absolute targets.
// [R10] Execution begins at the first step setting.
// [R11] Last step setting ends the program.
// [R12] Timed dwell is step time in 50 ms.
// [R13] Cyclic wraps to first; single holds idle.
// [R14] Settings act at once, no restart needed.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pps_sequencer
	import pps_pkg::*;
#(
	parameter int STEPS       = NUM_STEPS,
	parameter int UNIT_CYCLES = DWELL_UNIT_CYC
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [ADDR_W-1:0]        paddr,
	input  wire logic [31:0]              pwdata,
	output var  logic [31:0]              prdata,
	output var  logic                     pready,
	output var  logic                     pslverr,
	input  wire logic                     servo_on,
	input  wire logic                     positive_side_input,
	input  wire logic                     negative_side_input,
	input  wire logic                     step_advance_input,
	output var  logic [$clog2(STEPS)-1:0] step_index,
	output var  logic                     step_strobe,
	output var  logic                     pulse_enable,
	output var  logic                     target_absolute,
	output var  logic                     home_search,
	output var  logic                     program_done
);
	localparam int IW = $clog2(STEPS);

	initial begin
		if (STEPS != NUM_STEPS) $error("STEPS must match the sixteen dwell slots");
	end

	logic [15:0]   mode_r;
	logic [15:0]   target_r;
	logic [15:0]   first_r;
	logic [15:0]   last_r;
	logic [15:0]   dwell_r [STEPS];
	logic [31:0]   rdata_nxt;
	logic          err_nxt;
	logic          wr_en;
	logic          restart;
	logic [3:0]    pins_s;
	logic          servo_s;
	logic          pos_s;
	logic          neg_s;
	logic          adv_s;
	logic          adv_prev_r;
	logic          tmr_load;
	logic [15:0]   tmr_units;
	logic          tmr_done;
	pps_state_t    state_r;
	pps_state_t    state_nxt;
	logic [IW-1:0] step_nxt;
	logic          strobe_nxt;
	logic          pulse_nxt;
	logic          done_nxt;

	pps_sync #(
		.WIDTH (4)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({servo_on, positive_side_input, negative_side_input, step_advance_input}),
		.sync_out (pins_s)
	);

	assign servo_s = pins_s[3];
	assign pos_s   = pins_s[2];
	assign neg_s   = pins_s[1];
	assign adv_s   = pins_s[0];

	pps_dwell_timer #(
		.UNIT_CYCLES (UNIT_CYCLES)
	) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (tmr_load),
		.units   (tmr_units),
		.done    (tmr_done)
	);

	// Register access. Every setting is read live by the sequencer below.
	assign wr_en   = psel && penable && pready && pwrite;
	assign restart = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_RESTART];

	always_comb begin
		rdata_nxt = 32'h00000000;
		err_nxt   = 1'b0;
		if (pps_is_dwell(paddr)) begin
			rdata_nxt = {16'h0000, dwell_r[paddr[5:2]]};
		end else begin
			case (paddr)
				OFS_RSVD:   rdata_nxt = 32'h00000000;
				OFS_MODE:   rdata_nxt = {16'h0000, mode_r};
				OFS_TARGET: rdata_nxt = {16'h0000, target_r};
				OFS_FIRST:  rdata_nxt = {16'h0000, first_r};
				OFS_LAST:   rdata_nxt = {16'h0000, last_r};
				OFS_CTRL:   rdata_nxt = 32'h00000000;
				OFS_STATUS: rdata_nxt = {23'h000000, home_search, program_done, pulse_enable,
					state_r, step_index};
				default:    err_nxt = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata   <= 32'h00000000;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			mode_r   <= MODE_RST;
			target_r <= TARGET_RST;
			first_r  <= FIRST_RST;
			last_r   <= LAST_RST;
			for (int i = 0; i < STEPS; i++) begin
				dwell_r[i] <= DWELL_RST;
			end
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && err_nxt;
			if (psel && !penable) begin
				prdata <= rdata_nxt;
			end
			if (wr_en) begin
				if (pps_is_dwell(paddr)) begin
					dwell_r[paddr[5:2]] <= pwdata[15:0];
				end
				case (paddr)
					OFS_MODE:   mode_r   <= pwdata[15:0];
					OFS_TARGET: target_r <= pwdata[15:0];
					OFS_FIRST:  first_r  <= pwdata[15:0];
					OFS_LAST:   last_r   <= pwdata[15:0];
					default: begin
					end
				endcase
			end
		end
	end

	// Decoded settings, no shadow copies.
	logic          cyclic;
	logic          swap;
	logic          use_adv;
	logic          need_start;
	logic          edge_mode;
	logic          start_in;
	logic          start_req;
	logic          adv_rise;
	logic          advance;
	logic [IW-1:0] first_idx;
	logic [IW-1:0] last_idx;

	assign cyclic     = !mode_r[RUN_LSB];       // R1 R14
	assign swap       = mode_r[RUN_LSB + 1];    // R2
	assign use_adv    = mode_r[STEP_LSB];       // R3 R4
	assign need_start = mode_r[STEP_LSB + 1];   // R5 R6
	assign edge_mode  = mode_r[SIN_LSB];        // R8
	assign first_idx  = first_r[IW-1:0];        // R10
	assign last_idx   = last_r[IW-1:0];         // R11
	assign start_in   = swap ? neg_s : pos_s;   // R2
	assign start_req  = servo_s && (!need_start || start_in);
	assign adv_rise   = adv_s && !adv_prev_r;

	// Level mode needs the dwell spent and the input high; edge mode takes one rising edge.
	always_comb begin
		if (use_adv) begin
			advance = edge_mode ? adv_rise : (adv_s && tmr_done); // R4 R6 R8
		end else begin
			advance = tmr_done; // R3 R5 R12
		end
	end

	always_comb begin
		state_nxt  = state_r;
		step_nxt   = step_index;
		strobe_nxt = 1'b0;
		tmr_load   = 1'b0;
		done_nxt   = program_done;
		case (state_r)
			PPS_IDLE: begin
				if (start_req) begin
					state_nxt = PPS_DELAY; // R3 R4
					step_nxt  = first_idx; // R10
					tmr_load  = 1'b1;
					done_nxt  = 1'b0;
				end
			end
			PPS_DELAY: begin
				if (!start_req) begin
					state_nxt = PPS_IDLE;
				end else if (restart && need_start) begin
					step_nxt = first_idx; // R7
				end else if (tmr_done) begin
					state_nxt  = PPS_RUN;
					strobe_nxt = 1'b1;
					tmr_load   = 1'b1;
				end
			end
			PPS_RUN: begin
				if (!start_req) begin
					state_nxt = PPS_IDLE; // R5 R6
				end else if (restart && need_start) begin
					step_nxt   = first_idx; // R7
					strobe_nxt = 1'b1;
					tmr_load   = 1'b1;
				end else if (advance) begin
					if (step_index == last_idx) begin // R11
						if (cyclic) begin
							step_nxt   = first_idx; // R1 R13
							strobe_nxt = 1'b1;
							tmr_load   = 1'b1;
						end else begin
							state_nxt = PPS_HOLD; // R1 R13
							done_nxt  = 1'b1;
						end
					end else begin
						step_nxt   = step_index + IW'(1);
						strobe_nxt = 1'b1;
						tmr_load   = 1'b1; // R12
					end
				end
			end
			PPS_HOLD: begin
				if (!start_req) begin
					state_nxt = PPS_IDLE; // R13
				end
			end
			default: begin
				state_nxt = PPS_IDLE;
			end
		endcase
		tmr_units = (state_nxt == PPS_DELAY) ? START_DELAY_UNITS : dwell_r[step_nxt]; // R12
		pulse_nxt = (state_nxt == PPS_RUN); // R4
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r         <= PPS_IDLE;
			step_index      <= '0;
			step_strobe     <= 1'b0;
			pulse_enable    <= 1'b0;
			program_done    <= 1'b0;
			target_absolute <= 1'b0;
			home_search     <= 1'b0;
			adv_prev_r      <= 1'b0;
		end else begin
			state_r         <= state_nxt;
			step_index      <= step_nxt;
			step_strobe     <= strobe_nxt;
			pulse_enable    <= pulse_nxt;
			program_done    <= done_nxt;
			target_absolute <= target_r[0];           // R9
			home_search     <= swap ? pos_s : neg_s;  // R2
			adv_prev_r      <= adv_s;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_cyclic_wrap: assert property (state_r == PPS_RUN && start_req && !restart && advance
		&& step_index == last_idx && cyclic |=> step_index == $past(first_idx) && step_strobe) // R1
		else $error("cyclic program did not wrap to first step");
	chk_single_stop: assert property (state_r == PPS_RUN && start_req && !restart && advance
		&& step_index == last_idx && !cyclic |=> !pulse_enable && program_done) // R11
		else $error("single program did not stop after last step");
	chk_home_role: assert property (##1 home_search == $past(swap ? pos_s : neg_s)) // R2
		else $error("homing input role wrong");
	chk_start_drop: assert property (state_r == PPS_RUN && servo_s && need_start && !start_in
		|=> !pulse_enable) // R5
		else $error("pulses did not stop when start input dropped");
	chk_adv_no_halt: assert property (state_r == PPS_RUN && use_adv && !need_start && servo_s
		&& !adv_s && !advance && !restart |=> pulse_enable) // R4
		else $error("pulses halted while advance input inactive");
	chk_restart_step: assert property (state_r != PPS_IDLE && start_req && restart && need_start
		&& state_r != PPS_HOLD |=> step_index == $past(first_idx)) // R7
		else $error("restart did not return to first step");
	chk_edge_advance: assert property (state_r == PPS_RUN && use_adv && edge_mode && advance
		|-> adv_s && !adv_prev_r) // R8
		else $error("edge mode advanced without a rising edge");
	chk_abs_target: assert property (##1 target_absolute == $past(target_r[0])) // R9
		else $error("target interpretation not followed");
	chk_timed_advance: assert property (state_r == PPS_RUN && !use_adv && advance
		|-> tmr_done && !$past(tmr_load)) // R12
		else $error("timed step advanced before dwell expired");
	chk_start_first: assert property (state_r == PPS_IDLE && start_req
		|=> state_r == PPS_DELAY && step_index == $past(first_idx)) // R10
		else $error("program did not begin at first step");

	cov_cyclic_wrap: cover property (state_r == PPS_RUN && advance && step_index == last_idx
		&& cyclic);
	cov_single_done: cover property (state_r == PPS_RUN ##1 state_r == PPS_HOLD);
	cov_start_drop: cover property (state_r == PPS_RUN ##1 state_r == PPS_IDLE);
	cov_edge_step: cover property (state_r == PPS_RUN && use_adv && edge_mode && advance);
endmodule
`default_nettype wire

// [rtl/pps_sync.sv]
// Two-stage synchroniser for asynchronous input pins.
`timescale 1ns/1ps
`default_nettype none
module pps_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

// [verif/pps_host_model.sv]
// Host controller model that drives the start, homing and step-advance pins.
`timescale 1ns/1ps
`default_nettype none
module pps_host_model (
	input  wire logic pclk,
	input  wire logic swap,
	input  wire logic start_cmd,
	input  wire logic home_cmd,
	input  wire logic step_cmd,
	output var  logic positive_side_input,
	output var  logic negative_side_input,
	output var  logic step_advance_input
);
	initial begin
		positive_side_input = 1'b0;
		negative_side_input = 1'b0;
		step_advance_input  = 1'b0;
	end

	// The host wires its start and homing requests to the pins that the run mode selects.
	always @(posedge pclk) begin
		positive_side_input <= swap ? home_cmd : start_cmd;
		negative_side_input <= swap ? start_cmd : home_cmd;
		step_advance_input  <= step_cmd;
	end
endmodule
`default_nettype wire

// [verif/pps_sequencer_tb.sv]
// Self-checking testbench of the point-to-point step sequencer.
`timescale 1ns/1ps
`default_nettype none
module pps_sequencer_tb;
	import pps_pkg::*;
	localparam int UC = 4;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, servo_on;
	logic        pos_in, neg_in, adv_in, step_strobe, pulse_enable, target_absolute;
	logic        home_search, program_done, swap, start_cmd, home_cmd, step_cmd;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	logic [3:0]  step_index;
	logic [32:0] rd_q[$];
	logic [3:0]  st_q[$];
	int          n_mismatch, checked, n_str;

	pps_sequencer #(.STEPS(16), .UNIT_CYCLES(UC)) i_pps_sequencer (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .servo_on(servo_on),
		.positive_side_input(pos_in), .negative_side_input(neg_in),
		.step_advance_input(adv_in), .step_index(step_index),
		.step_strobe(step_strobe), .pulse_enable(pulse_enable),
		.target_absolute(target_absolute), .home_search(home_search),
		.program_done(program_done));

	pps_host_model i_pps_host_model (
		.pclk(pclk), .swap(swap), .start_cmd(start_cmd), .home_cmd(home_cmd),
		.step_cmd(step_cmd), .positive_side_input(pos_in),
		.negative_side_input(neg_in), .step_advance_input(adv_in));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic tmo();
		n_mismatch++;
		$display("BAD t=%0t got=%h exp=%h", $time, 0, 1);
		end_sim();
	endtask

	// The request is held until pready is seen high at a rising edge.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			input logic [32:0] e);
		int i;
		rd_q.push_back(e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) tmo();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wstr(input int n);
		int t;
		t = n_str + n;
		repeat (400) begin
			if (n_str >= t) return;
			@(posedge pclk);
		end
		tmo();
	endtask

	task automatic wlvl(ref logic s, input logic v);
		repeat (100) begin
			@(posedge pclk);
			if (s === v) return;
		end
		tmo();
	endtask

	task automatic run(input logic [15:0] m, input int n);
		int j;
		apb(1'b1, OFS_MODE, {16'h0, m}, '0);
		for (j = 0; j < n; j++) st_q.push_back(4'(2 + j % 2));
		servo_on <= 1'b1;
		wstr(n);
	endtask

	task automatic stop();
		servo_on <= 1'b0;
		start_cmd <= 1'b0;
		step_cmd <= 1'b0;
		wlvl(pulse_enable, 1'b0);
	endtask

	// Every completed access and every issued step is compared with the oldest note.
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			chk({pslverr, pwrite ? 32'h0 : prdata}, rd_q.size() ? rd_q.pop_front() : '1);
		end
		if (step_strobe === 1'b1) begin
			n_str++;
			chk(33'(step_index), 33'(st_q.size() ? st_q.pop_front() : 4'hX));
		end
	end

	initial begin
		int          k;
		logic [11:0] ra[6];
		logic [15:0] rv[6];
		ra = '{OFS_RSVD, OFS_MODE, OFS_TARGET, OFS_FIRST, OFS_LAST, OFS_DWELL};
		rv = '{16'h0000, MODE_RST, TARGET_RST, FIRST_RST, LAST_RST, DWELL_RST};
		{presetn, psel, penable, pwrite, servo_on, swap} = '0;
		{start_cmd, home_cmd, step_cmd} = '0;
		paddr = '0;
		pwdata = '0;
		rnd = 32'hE3D28920;
		n_mismatch = 0;
		checked = 0;
		n_str = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (k = 0; k < 6; k++) apb(1'b0, ra[k], 32'h0, {17'h0, rv[k]});
		apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
		apb(1'b1, 12'h020, 32'h5, {1'b1, 32'h0});
		rnd = lfsr(rnd);
		apb(1'b1, OFS_DWELL + 12'h03C, rnd, '0);
		apb(1'b0, OFS_DWELL + 12'h03C, 32'h0, {17'h0, rnd[15:0]});
		apb(1'b1, OFS_TARGET, 32'h1, '0);
		wlvl(target_absolute, 1'b1);
		chk(33'(target_absolute), 33'h1);
		$display("test registers done");
		apb(1'b1, OFS_FIRST, 32'h2, '0);
		apb(1'b1, OFS_LAST, 32'h3, '0);
		run(16'h0000, 5);
		chk(33'(pulse_enable), 33'h1);
		stop();
		run(16'h0001, 2);
		wlvl(program_done, 1'b1);
		chk(33'(pulse_enable), 33'h0);
		stop();
		step_cmd <= 1'b1;
		run(16'h0010, 3);
		stop();
		$display("test timed and level runs done");
		swap <= 1'b1;
		home_cmd <= 1'b1;
		// A longer dwell keeps the next step clear of the start drop, which the pins see late.
		apb(1'b1, OFS_DWELL + 12'h008, 32'h4, '0);
		apb(1'b1, OFS_MODE, 32'h22, '0);
		servo_on <= 1'b1;
		wlvl(home_search, 1'b1);
		chk(33'(pulse_enable), 33'h0);
		st_q.push_back(4'h2);
		start_cmd <= 1'b1;
		wstr(1);
		start_cmd <= 1'b0;
		wlvl(pulse_enable, 1'b0);
		stop();
		swap <= 1'b0;
		home_cmd <= 1'b0;
		$display("test start gated run done");
		// A held step input in edge mode must give one advance only.
		apb(1'b1, OFS_MODE, 32'h130, '0);
		st_q.push_back(4'h2);
		st_q.push_back(4'h3);
		start_cmd <= 1'b1;
		servo_on <= 1'b1;
		wstr(1);
		repeat (12) @(posedge pclk);
		step_cmd <= 1'b1;
		wstr(1);
		// A restart while running must issue the first step again, once.
		st_q.push_back(4'h2);
		apb(1'b1, OFS_CTRL, 32'h1, '0);
		repeat (40) @(posedge pclk);
		chk(33'(st_q.size()), 33'h0);
		stop();
		apb(1'b0, OFS_STATUS, 32'h0, {17'h0, 16'h0002});
		$display("test edge run done");
		end_sim();
	end
endmodule
`default_nettype wire
